// File: hw/ddd_pkg.sv
// Constants and shared definitions for the dial digit decoder.
// What this block does
// - Optionally remap tone code ten for digit zero to a plain zero.
// - One-of-sixteen decoder asserts exactly one line chosen by the digit code.
// - The asserted line holds until a new digit arrives, or the zero remap option changes while code ten is held.
// - Convert the latched raw code, before zero remap, into row plus column lines; column three can be inhibited.
// - Row and column outputs are meaningful only while digit valid is high.
// - Optionally force all row and column lines low while digit valid is low.
// - Each dial pulse starts or restarts the timeout; the first pulse of a train resets the counter at once.
// - Counter increment is delayed after its reset so the two never overlap.
// - After 0.2 second without pulses the timeout ends and loads the latch once.
// - Timeout exceeds the 0.125 second gap of an 8 pps slow dial.
// - Pulse counter counts in plain binary so ten pulses give code ten.
// - Counter and tone code are ORed into the latch input, zero when undriven.
// - Latch holds the last digit from either source until the next one loads.
// - While the loop shows continuous break, rotary latch loading is suppressed.
package ddd_pkg;

    localparam int CODE_W = 4;
    localparam int LINES = 16;
    localparam int CLK_HZ = 20_000_000;

    // End-of-digit timeout, and the slow dial gap it must exceed.
    localparam int TIMEOUT_MS = 200;
    localparam int SLOW_DIAL_PPS = 8;
    localparam int SLOW_GAP_MS = 1000 / SLOW_DIAL_PPS;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int TIMER_W = 22;

    // Receiver code for digit zero in hexadecimal format.
    localparam logic [3:0] CODE_ZERO_TONE = 4'hA;
    localparam logic [3:0] CODE_PLAIN_ZERO = 4'h0;

    // Values after reset.
    localparam logic [3:0] RST_CODE = 4'h0;
    localparam logic [15:0] RST_ONE_HOT = 16'h0001;

    // Column three carries the 1633 Hz tone.
    localparam int COL_INHIBIT_POS = 3;

endpackage

// File: hw/ddd_sync_edge.sv
// Two-flop synchroniser with rising edge detection for a group of levels.
`timescale 1ns/100ps
module ddd_sync_edge #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Asynchronous levels in
    input wire logic [W-1:0] level_i,
    // Synchronised levels and one-cycle rising edge pulses
    output logic [W-1:0] level_o,
    output logic [W-1:0] rise_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
    } ddd_sync_s;

    ddd_sync_s state_reg;
    ddd_sync_s state_next;

    // The first stage is read only by the second stage.
    always_comb begin
        state_next = state_reg;
        state_next.meta = level_i;
        state_next.sync = state_reg.meta;
        state_next.prev = state_reg.sync;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_o = state_reg.sync;
    assign rise_o = state_reg.sync & ~state_reg.prev;

endmodule

// File: hw/ddd_dial_digit_decoder.sv
// Rotary pulse counter, tone code merge, digit latch and output decoders.
`timescale 1ns/100ps
module ddd_dial_digit_decoder #(
    parameter int TIMEOUT_CYCLES = ddd_pkg::TIMEOUT_CYCLES,
    parameter int TIMER_W = ddd_pkg::TIMER_W
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Tone receiver
    input wire logic [3:0] tone_code_i,
    input wire logic digit_valid_i,
    // Loop detector, high means loop break
    input wire logic loop_break_i,
    // Options
    input wire logic zero_remap_en_i,
    input wire logic col3_inhibit_i,
    input wire logic blank_2of8_en_i,
    // Held digit
    output logic [3:0] digit_code_o,
    output logic digit_load_o,
    // One-of-sixteen decoder
    output logic [15:0] one_hot_o,
    // Two-of-eight decoder
    output logic [3:0] row_o,
    output logic [3:0] col_o,
    output logic row_col_valid_o,
    // Rotary status
    output logic [3:0] pulse_count_o,
    output logic timeout_active_o
);

    typedef struct packed {
        logic [TIMER_W-1:0] timer;
        logic timeout_active;
        logic count_pending;
        logic [3:0] pulse_counter;
        logic [3:0] raw_code;
        logic [3:0] digit_code;
        logic digit_load;
        logic [15:0] one_hot;
        logic [3:0] row;
        logic [3:0] col;
        logic row_col_valid;
    } ddd_state_s;

    localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(TIMEOUT_CYCLES - 1);
    localparam logic [TIMER_W-1:0] TIMER_ONE = TIMER_W'(1);

    ddd_state_s state_reg;
    ddd_state_s state_next;

    logic [1:0] sync_level;
    logic [1:0] sync_rise;
    logic loop_level;
    logic dial_pulse;
    logic dv_level;
    logic dv_rise;

    ddd_sync_edge #(
        .W(2)
    ) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .level_i({digit_valid_i, loop_break_i}),
        .level_o(sync_level),
        .rise_o(sync_rise)
    );

    // A dial pulse is taken at the start of each loop break.
    assign loop_level = sync_level[0];
    assign dial_pulse = sync_rise[0];
    assign dv_level = sync_level[1];
    assign dv_rise = sync_rise[1];

    // Maps a binary digit code onto its row and column lines.
    function automatic logic [7:0] ddd_row_col(input logic [3:0] code);
        logic [1:0] r;
        logic [1:0] c;
        r = 2'h0;
        c = 2'h0;
        unique case (code)
            4'h1: begin
                r = 2'h0;
                c = 2'h0;
            end
            4'h2: begin
                r = 2'h0;
                c = 2'h1;
            end
            4'h3: begin
                r = 2'h0;
                c = 2'h2;
            end
            4'h4: begin
                r = 2'h1;
                c = 2'h0;
            end
            4'h5: begin
                r = 2'h1;
                c = 2'h1;
            end
            4'h6: begin
                r = 2'h1;
                c = 2'h2;
            end
            4'h7: begin
                r = 2'h2;
                c = 2'h0;
            end
            4'h8: begin
                r = 2'h2;
                c = 2'h1;
            end
            4'h9: begin
                r = 2'h2;
                c = 2'h2;
            end
            4'hA: begin
                r = 2'h3;
                c = 2'h1;
            end
            4'hB: begin
                r = 2'h3;
                c = 2'h0;
            end
            4'hC: begin
                r = 2'h3;
                c = 2'h2;
            end
            4'hD: begin
                r = 2'h0;
                c = 2'h3;
            end
            4'hE: begin
                r = 2'h1;
                c = 2'h3;
            end
            4'hF: begin
                r = 2'h2;
                c = 2'h3;
            end
            4'h0: begin
                r = 2'h3;
                c = 2'h3;
            end
        endcase
        ddd_row_col = {4'h1 << r, 4'h1 << c};
    endfunction

    logic timeout_end;
    logic rotary_load;
    logic tone_load;
    logic [3:0] latch_in;
    logic [3:0] code_out;
    logic [7:0] rc;
    logic [3:0] col_mask;
    logic blank;

    always_comb begin
        state_next = state_reg;
        timeout_end = 1'b0;

        // Timeout: retriggered on every pulse, counts down otherwise.
        if (dial_pulse) begin
            // The reload span must stay above the slowest dial's pulse gap.
            state_next.timer = TIMER_LOAD;
            state_next.timeout_active = 1'b1;
        end else if (state_reg.timeout_active) begin
            if (state_reg.timer <= TIMER_ONE) begin
                state_next.timeout_active = 1'b0;
                timeout_end = 1'b1;
            end
            state_next.timer = state_reg.timer - TIMER_ONE;
        end

        // The first pulse of a train clears the counter in its own cycle;
        // the increment follows one cycle later, so clear and count are
        // never applied together.
        state_next.count_pending = dial_pulse;
        if (dial_pulse && !state_reg.timeout_active) begin
            state_next.pulse_counter = 4'h0;
        end else if (state_reg.count_pending) begin
            state_next.pulse_counter = state_reg.pulse_counter + 4'h1;
        end

        // A hang-up leaves the loop in break when the timeout ends, and
        // its single spurious count must not replace the held digit.
        rotary_load = timeout_end && !loop_level;
        tone_load = dv_rise;
        latch_in = (state_reg.pulse_counter & {4{rotary_load}})
            | (tone_code_i & {4{tone_load}});

        state_next.digit_load = rotary_load || tone_load;
        if (rotary_load || tone_load) begin
            state_next.raw_code = latch_in;
        end

        if (zero_remap_en_i && state_next.raw_code == ddd_pkg::CODE_ZERO_TONE) begin
            code_out = ddd_pkg::CODE_PLAIN_ZERO;
        end else begin
            code_out = state_next.raw_code;
        end
        state_next.digit_code = code_out;
        state_next.one_hot = 16'h0001 << code_out;

        // Row and column lines follow the receiver's own binary code.
        rc = ddd_row_col(state_next.raw_code);
        col_mask = 4'hF;
        if (col3_inhibit_i) begin
            col_mask[ddd_pkg::COL_INHIBIT_POS] = 1'b0;
        end
        blank = blank_2of8_en_i && !dv_level;
        state_next.row = blank ? 4'h0 : rc[7:4];
        state_next.col = blank ? 4'h0 : (rc[3:0] & col_mask);
        state_next.row_col_valid = dv_level;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg.timer <= '0;
            state_reg.timeout_active <= 1'b0;
            state_reg.count_pending <= 1'b0;
            state_reg.pulse_counter <= 4'h0;
            state_reg.raw_code <= ddd_pkg::RST_CODE;
            state_reg.digit_code <= ddd_pkg::RST_CODE;
            state_reg.digit_load <= 1'b0;
            state_reg.one_hot <= ddd_pkg::RST_ONE_HOT;
            state_reg.row <= 4'h0;
            state_reg.col <= 4'h0;
            state_reg.row_col_valid <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign digit_code_o = state_reg.digit_code;
    assign digit_load_o = state_reg.digit_load;
    assign one_hot_o = state_reg.one_hot;
    assign row_o = state_reg.row;
    assign col_o = state_reg.col;
    assign row_col_valid_o = state_reg.row_col_valid;
    assign pulse_count_o = state_reg.pulse_counter;
    assign timeout_active_o = state_reg.timeout_active;

endmodule

// File: bench/ddd_asserts.sv
// Port checks for the dial digit decoder.
`timescale 1ns/100ps
module ddd_asserts #(
    parameter int TIMEOUT_CYCLES = 40
) (
    // Watched ports
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic loop_break_i,
    input wire logic zero_remap_en_i,
    input wire logic blank_2of8_en_i,
    input wire logic [3:0] digit_code_o,
    input wire logic digit_load_o,
    input wire logic [15:0] one_hot_o,
    input wire logic [3:0] row_o,
    input wire logic [3:0] col_o,
    input wire logic row_col_valid_o,
    input wire logic [3:0] pulse_count_o,
    input wire logic timeout_active_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Raw loop history tells a steady break from a pulse train, since the sync stage hides it.
    logic [4:0] lb_h;
    int run;
    always_ff @(posedge clock_i) begin
        lb_h <= {lb_h[3:0], loop_break_i};
        run <= (lb_h[0] && !lb_h[1]) ? 0 : run + 1;
    end
    property p_onehot; one_hot_o == 16'h0001 << digit_code_o; endproperty
    a_onehot: assert property (p_onehot) else $error("one-hot mismatch");
    property p_hold;
        !digit_load_o && $past(zero_remap_en_i) == $past(zero_remap_en_i, 2)
        |-> $stable(digit_code_o);
    endproperty
    a_hold: assert property (p_hold) else $error("digit changed without load");
    property p_remap;
        row_o == 4'h8 && col_o == 4'h2
        |-> digit_code_o == ($past(zero_remap_en_i) ? 4'h0 : 4'hA);
    endproperty
    a_remap: assert property (p_remap) else $error("zero remap wrong");
    property p_blank;
        blank_2of8_en_i && $past(blank_2of8_en_i) && !row_col_valid_o
        |-> {row_o, col_o} == 8'h00;
    endproperty
    a_blank: assert property (p_blank) else $error("rows not blanked");
    property p_first; $rose(timeout_active_o) |=> pulse_count_o == 4'h1; endproperty
    a_first: assert property (p_first) else $error("first pulse count");
    property p_tlen;
        $fell(timeout_active_o) |-> run inside {[TIMEOUT_CYCLES - 1:TIMEOUT_CYCLES + 1]};
    endproperty
    a_tlen: assert property (p_tlen) else $error("timeout length");
    property p_rotld; $fell(timeout_active_o) && lb_h[4:1] == 4'h0 |-> digit_load_o; endproperty
    a_rotld: assert property (p_rotld) else $error("no load at timeout");
    property p_onhook; $fell(timeout_active_o) && &lb_h[4:1] |-> !digit_load_o; endproperty
    a_onhook: assert property (p_onhook) else $error("load while on hook");
endmodule
bind ddd_dial_digit_decoder ddd_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_ddd_asserts (
    .clock_i, .rst_n_i, .loop_break_i, .zero_remap_en_i, .blank_2of8_en_i, .digit_code_o,
    .digit_load_o, .one_hot_o, .row_o, .col_o, .row_col_valid_o, .pulse_count_o,
    .timeout_active_o);

// File: bench/ddd_tone_loop_model.sv
// Tone receiver and loop detector stand-in driving the decoder inputs.
`timescale 1ns/100ps
module ddd_tone_loop_model (
    // Clock
    input wire logic clock_i,
    // Receiver and loop levels
    output logic [3:0] tone_code_o,
    output logic digit_valid_o,
    output logic loop_break_o
);
    initial begin
        tone_code_o = 4'h0;
        digit_valid_o = 1'b0;
        loop_break_o = 1'b0;
    end
    task automatic tone(input logic [3:0] c);
        @(posedge clock_i) #1 tone_code_o = c;
        @(posedge clock_i) #1 digit_valid_o = 1'b1;
    endtask
    // The cleared code also reads as digit D, so a pause is not a distinct value.
    task automatic pause();
        @(posedge clock_i) #1 digit_valid_o = 1'b0;
        repeat (2) @(posedge clock_i);
        #1 tone_code_o = 4'h0;
    endtask
    task automatic dial(input int n);
        repeat (n) begin
            @(posedge clock_i) #1 loop_break_o = 1'b1;
            repeat (4) @(posedge clock_i);
            #1 loop_break_o = 1'b0;
            repeat (3) @(posedge clock_i);
        end
    endtask
    task automatic hook(input logic b);
        @(posedge clock_i) #1 loop_break_o = b;
    endtask
endmodule

// File: bench/test_dial_digit_decoder.sv
// Self-checking bench for the dial digit decoder with tone and rotary traffic.
`timescale 1ns/100ps
module test_dial_digit_decoder;
    localparam int TO = 40;
    localparam logic [31:0] ROWS = 32'h93FA9503;
    localparam logic [31:0] COLS = 32'hFE192493;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic zero_remap_en_i = 1'b0;
    logic col3_inhibit_i = 1'b0;
    logic blank_2of8_en_i = 1'b0;
    logic [3:0] tone_code_i, digit_code_o, row_o, col_o, pulse_count_o;
    logic digit_valid_i, loop_break_i, digit_load_o, row_col_valid_o, timeout_active_o;
    logic [15:0] one_hot_o;
    int err_total = 0;
    int comparisons = 0;
    int dl[4] = '{10, 16, 1, 15};
    ddd_tone_loop_model u_ddd_tone_loop_model (.clock_i, .tone_code_o(tone_code_i),
        .digit_valid_o(digit_valid_i), .loop_break_o(loop_break_i));
    ddd_dial_digit_decoder #(.TIMEOUT_CYCLES(TO)) u_ddd_dial_digit_decoder (.clock_i,
        .rst_n_i, .tone_code_i, .digit_valid_i, .loop_break_i, .zero_remap_en_i,
        .col3_inhibit_i, .blank_2of8_en_i, .digit_code_o, .digit_load_o, .one_hot_o, .row_o,
        .col_o, .row_col_valid_o, .pulse_count_o, .timeout_active_o);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [3:0] shown(input logic [3:0] c);
        return (zero_remap_en_i && c == 4'hA) ? 4'h0 : c;
    endfunction
    function automatic logic [7:0] rc(input logic [3:0] c);
        logic [3:0] k;
        k = 4'h1 << COLS[2 * c +: 2];
        return {4'h1 << ROWS[2 * c +: 2], col3_inhibit_i ? k & 4'h7 : k};
    endfunction
    task automatic wait_load(input int lim, input logic want);
        logic seen;
        seen = 1'b0;
        repeat (lim) begin
            @(posedge clock_i) #1;
            if (digit_load_o === 1'b1) begin
                seen = 1'b1;
                break;
            end
        end
        chk(seen, want);
    endtask
    task automatic do_tone(input logic [3:0] c);
        u_ddd_tone_loop_model.tone(c);
        wait_load(8, 1'b1);
        chk(digit_code_o, shown(c));
        chk({row_o, col_o}, rc(c));
        u_ddd_tone_loop_model.pause();
        repeat (3) @(posedge clock_i);
        #1 chk(row_col_valid_o, 0);
        chk({row_o, col_o}, blank_2of8_en_i ? 8'h00 : rc(c));
        chk(digit_code_o, shown(c));
        $display("tone %h done", c);
    endtask
    task automatic do_dial(input int n);
        u_ddd_tone_loop_model.dial(n);
        wait_load(TO + 20, 1'b1);
        chk(digit_code_o, shown(4'(n)));
        $display("dial %0d done", n);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        forever #25 clock_i = ~clock_i;
    end
    // The whole sequence needs about 1000 cycles; the margin covers slow loads.
    initial begin
        repeat (5000) @(posedge clock_i);
        err_total++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h93CBB06C));
        repeat (4) @(posedge clock_i);
        #1 rst_n_i = 1'b1;
        for (int i = 0; i < 20; i++) begin
            {zero_remap_en_i, col3_inhibit_i, blank_2of8_en_i} = 3'($urandom);
            do_tone(i < 16 ? 4'(i) : 4'($urandom));
        end
        foreach (dl[k]) begin
            zero_remap_en_i = 1'($urandom);
            do_dial(dl[k]);
        end
        do_dial(1 + $urandom % 15);
        do_dial(3);
        u_ddd_tone_loop_model.hook(1'b1);
        wait_load(TO + 20, 1'b0);
        chk(digit_code_o, 4'h3);
        u_ddd_tone_loop_model.hook(1'b0);
        $display("on hook done");
        report_and_stop();
    end
endmodule
